// >>> shared/wrx_pkg.sv
// wrx_pkg: constants shared by the wireless receiver control blocks
package wrx_pkg;
    // ------------------------------------------------------------
    // clock and link timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 250_000_000; // system clock rate
    localparam int BIT_RATE_BPS = 2000; // load modulation bit rate
    localparam int HALF_BIT_CYC = CLK_HZ / (2 * BIT_RATE_BPS); // cycles per half bit
    localparam logic [3:0] PRE_BITS = 4'hb; // preamble ones
    localparam logic [3:0] FRAME_LAST = 4'ha; // last bit of an 11-bit byte frame

    // ------------------------------------------------------------
    // packet headers and fixed contents
    // ------------------------------------------------------------
    localparam logic [7:0] HDR_SIG = 8'h01; // signal strength
    localparam logic [7:0] HDR_EPT = 8'h02; // end power transfer
    localparam logic [7:0] HDR_CE = 8'h03; // control error
    localparam logic [7:0] HDR_RP = 8'h04; // received power
    localparam logic [7:0] HDR_CFG = 8'h51; // configuration
    localparam logic [7:0] HDR_ID = 8'h71; // identification
    localparam logic [7:0] EPT_REASON = 8'h00; // end code, arbitrary
    localparam logic [39:0] CFG_BYTES = 40'h00_00_00_00_0a; // config body, arbitrary
    localparam logic [55:0] ID_BYTES = 56'h00_00_00_00_00_00_10; // identity, arbitrary
    localparam logic [2:0] LEN_SIG = 3'h1;
    localparam logic [2:0] LEN_CFG = 3'h5;
    localparam logic [2:0] LEN_ID = 3'h7;

    // ------------------------------------------------------------
    // rectifier targets in millivolts, current limit and control error pacing
    // ------------------------------------------------------------
    localparam logic [15:0] VT_LT10_MV = 16'd7080;
    localparam logic [15:0] VT_LT20_MV = 16'd6280;
    localparam logic [15:0] VT_LT40_MV = 16'd5530;
    localparam logic [15:0] VT_HI_MV = 16'd5110;
    localparam logic [15:0] VRAMP_MV = 16'd7000; // start-up level
    localparam logic [15:0] MAX_OUTPUT_CURRENT_MA = 16'd1000; // max current reset value
    localparam logic [3:0] CE_SHIFT = 4'h5; // mV per control error step = 32
    localparam logic [3:0] RP_EVERY = 4'h8; // control errors per power report

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MAX_OUTPUT_CURRENT = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_TARGET = 8'h0c;
    localparam logic [7:0] REG_REPORT = 8'h10;
    localparam int CTRL_RUN = 0; // receiver run enable
    localparam int CTRL_STOP = 1; // software end-transfer request
    localparam logic [1:0] CTRL_RST = 2'h1;

    // ------------------------------------------------------------
    // receiver sequence, gray coded along the path
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SIG = 3'b001,
        ST_CFG = 3'b011,
        ST_ID = 3'b010,
        ST_RAMP = 3'b110,
        ST_ACTIVE = 3'b111,
        ST_EPT = 3'b101,
        ST_STOP = 3'b100
    } wrx_state_e;
endpackage : wrx_pkg

// >>> shared/wrx_pkt_if.sv
// wrx_pkt_if: packet hand-off between sequencer and modulator
`timescale 1ns/1ps
interface wrx_pkt_if;
    logic valid; // packet offered
    logic ready; // modulator idle
    logic [7:0] hdr; // header byte
    logic [2:0] len; // message byte count
    logic [55:0] body; // message bytes, first in low byte
    modport src (output valid, output hdr, output len, output body, input ready);
    modport snk (input valid, input hdr, input len, input body, output ready);
endinterface : wrx_pkt_if

// >>> verilog/wrx_vtarget.sv
// wrx_vtarget: rectifier target chosen from output current share
`timescale 1ns/1ps
module wrx_vtarget
    import wrx_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] iout_ma_i,
    input wire logic [15:0] max_output_current_ma_i,
    output logic [15:0] target_mv_o
);
    // ------------------------------------------------------------
    // share test: iout / max_output_current below num/den
    // ------------------------------------------------------------
    function automatic logic below(input logic [15:0] i, input logic [15:0] m,
                                   input logic [3:0] num, input logic [3:0] den);
        logic [19:0] lhs;
        logic [19:0] rhs;
        lhs = i * den;
        rhs = m * num;
        below = lhs < rhs;
    endfunction : below

    logic [15:0] target_r; // registered target
    logic [15:0] target_nxt;

    // band select, recomputed whenever current moves
    always_comb begin
        if (below(iout_ma_i, max_output_current_ma_i, 4'h1, 4'ha)) begin
            target_nxt = VT_LT10_MV;
        end else if (below(iout_ma_i, max_output_current_ma_i, 4'h1, 4'h5)) begin
            target_nxt = VT_LT20_MV;
        end else if (below(iout_ma_i, max_output_current_ma_i, 4'h2, 4'h5)) begin
            target_nxt = VT_LT40_MV;
        end else begin
            target_nxt = VT_HI_MV;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            target_r <= VT_LT10_MV;
        end else begin
            target_r <= target_nxt;
        end
    end

    assign target_mv_o = target_r;
endmodule : wrx_vtarget

// >>> verilog/wrx_modulator.sv
// wrx_modulator: packet framing and differential bi-phase load modulation
`timescale 1ns/1ps
module wrx_modulator
    import wrx_pkg::*;
#(
    parameter int HALF_BIT_CYCLES = HALF_BIT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    wrx_pkt_if.snk pkt,
    output logic mod_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam int CW = $clog2(HALF_BIT_CYCLES + 1);
    localparam logic [CW-1:0] HALF_LAST = CW'(HALF_BIT_CYCLES - 1);

    function automatic logic [10:0] frame(input logic [7:0] b);
        frame = {1'b1, ~^b, b, 1'b0}; // stop, odd parity, data lsb first, start
    endfunction : frame

    logic busy_r, busy_nxt; // packet on the coil
    logic pre_r, pre_nxt; // in preamble
    logic half_r, half_nxt; // second half of bit
    logic line_r, line_nxt; // switch level
    logic [CW-1:0] cnt_r, cnt_nxt; // half-bit timer
    logic [3:0] bit_r, bit_nxt; // bit within preamble or frame
    logic [3:0] byte_r, byte_nxt; // 0 header, then message, then checksum
    logic [10:0] frm_r, frm_nxt; // shifting byte frame
    logic [7:0] chk_r, chk_nxt; // running xor checksum
    logic [2:0] len_r, len_nxt;
    logic [55:0] body_r, body_nxt;
    logic cur_bit;
    logic [7:0] nb;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        busy_nxt = busy_r;
        pre_nxt = pre_r;
        half_nxt = half_r;
        line_nxt = line_r;
        cnt_nxt = cnt_r;
        bit_nxt = bit_r;
        byte_nxt = byte_r;
        frm_nxt = frm_r;
        chk_nxt = chk_r;
        len_nxt = len_r;
        body_nxt = body_r;
        nb = body_r[{byte_r[2:0], 3'b000} +: 8];
        cur_bit = pre_r | frm_r[0];
        if (!busy_r) begin
            // accept a packet; first edge opens the preamble
            if (pkt.valid) begin
                busy_nxt = 1'b1;
                pre_nxt = 1'b1;
                half_nxt = 1'b0;
                cnt_nxt = '0;
                bit_nxt = '0;
                byte_nxt = '0;
                frm_nxt = frame(pkt.hdr);
                chk_nxt = pkt.hdr;
                len_nxt = pkt.len;
                body_nxt = pkt.body;
                line_nxt = ~line_r;
            end
        end else if (cnt_r != HALF_LAST) begin
            cnt_nxt = cnt_r + 1'b1;
        end else begin
            cnt_nxt = '0;
            if (!half_r) begin
                // mid-bit edge marks a one
                half_nxt = 1'b1;
                line_nxt = line_r ^ cur_bit;
            end else begin
                half_nxt = 1'b0;
                line_nxt = ~line_r; // every bit opens with an edge
                bit_nxt = bit_r + 1'b1;
                frm_nxt = pre_r ? frm_r : {1'b0, frm_r[10:1]}; // header frame waits out the preamble
                if (pre_r) begin
                    if (bit_r == PRE_BITS - 1'b1) begin
                        pre_nxt = 1'b0;
                        bit_nxt = '0;
                    end
                end else if (bit_r == FRAME_LAST) begin
                    bit_nxt = '0;
                    byte_nxt = byte_r + 1'b1;
                    if (byte_r == {1'b0, len_r} + 4'h1) begin
                        // checksum sent: release the coil
                        busy_nxt = 1'b0;
                        line_nxt = 1'b0;
                    end else if (byte_r < {1'b0, len_r}) begin
                        frm_nxt = frame(nb);
                        chk_nxt = chk_r ^ nb;
                    end else begin
                        frm_nxt = frame(chk_r);
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
            pre_r <= 1'b0;
            half_r <= 1'b0;
            line_r <= 1'b0;
            cnt_r <= '0;
            bit_r <= '0;
            byte_r <= '0;
            frm_r <= '0;
            chk_r <= '0;
            len_r <= '0;
            body_r <= '0;
        end else begin
            busy_r <= busy_nxt;
            pre_r <= pre_nxt;
            half_r <= half_nxt;
            line_r <= line_nxt;
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            byte_r <= byte_nxt;
            frm_r <= frm_nxt;
            chk_r <= chk_nxt;
            len_r <= len_nxt;
            body_r <= body_nxt;
        end
    end

    assign pkt.ready = ~busy_r;
    assign mod_o = line_r;
endmodule : wrx_modulator

// >>> verilog/wrx_top.sv
// wrx_top: receiver power control sequencer with wishbone registers
//
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module wrx_top
    import wrx_pkg::*;
#(
    parameter int HALF_BIT_CYCLES = HALF_BIT_CYC,
    parameter logic [15:0] MAX_OUTPUT_CURRENT_RESET = MAX_OUTPUT_CURRENT_MA
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // pins
    input wire logic ping_power_i,
    input wire logic mode_select_a_i,
    input wire logic mode_select_b_i,
    input wire logic wired_supply_i,
    input wire logic temperature_control_i,
    // converter samples, same clock
    input wire logic [15:0] rectifier_voltage_i,
    input wire logic [15:0] output_current_i,
    input wire logic [15:0] received_power_sense_i,
    output logic load_modulation_switch_o,
    output logic output_enable_o
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pin_s1_r; // first stage, read only by second
    logic [4:0] pin_s2_r;
    logic ping_s, sel_a_s, sel_b_s, wired_s, temp_s;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s1_r <= {ping_power_i, mode_select_a_i, mode_select_b_i, wired_supply_i,
                         temperature_control_i};
            pin_s2_r <= pin_s1_r;
        end
    end

    assign {ping_s, sel_a_s, sel_b_s, wired_s, temp_s} = pin_s2_r;

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    wrx_pkt_if pkt ();
    logic [15:0] target_mv; // live rectifier target
    logic [15:0] max_output_current_r; // max current setting, mA
    logic mod_line;

    wrx_vtarget u_vtarget (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .iout_ma_i(output_current_i),
        .max_output_current_ma_i(max_output_current_r),
        .target_mv_o(target_mv)
    );

    wrx_modulator #(
        .HALF_BIT_CYCLES(HALF_BIT_CYCLES)
    ) u_mod (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pkt(pkt.snk),
        .mod_o(mod_line)
    );

    assign load_modulation_switch_o = mod_line; // flop inside modulator

    // ------------------------------------------------------------
    // end conditions
    // ------------------------------------------------------------
    logic [1:0] ctrl_r, ctrl_nxt; // run, stop request
    logic end_cond; // any reason to stop the transmitter

    // mode a high, wired power with priority, hot/ctrl pin, software
    assign end_cond = sel_a_s | (wired_s & ~sel_b_s) | temp_s | ~ctrl_r[CTRL_RUN]
                      | ctrl_r[CTRL_STOP];

    // ------------------------------------------------------------
    // packet contents
    // ------------------------------------------------------------
    function automatic logic [7:0] ce_value(input logic [15:0] tgt, input logic [15:0] vr);
        logic signed [16:0] diff;
        logic signed [16:0] step;
        diff = $signed({1'b0, tgt}) - $signed({1'b0, vr});
        step = diff >>> CE_SHIFT;
        if (step > 17'sd127) begin
            ce_value = 8'h7f;
        end else if (step < -17'sd128) begin
            ce_value = 8'h80;
        end else begin
            ce_value = step[7:0];
        end
    endfunction : ce_value

    logic [7:0] ce_byte; // error byte for current goal
    logic [7:0] rp_byte; // power byte from sense pin
    logic [15:0] goal_mv;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    wrx_state_e state_r, state_nxt;
    logic contract_r, contract_nxt; // power contract held
    logic out_en_r, out_en_nxt; // output supply enable
    logic [3:0] ce_cnt_r, ce_cnt_nxt; // control errors since report
    logic [7:0] last_ce_r, last_ce_nxt;
    logic [7:0] last_rp_r, last_rp_nxt;
    logic take; // packet accepted this cycle

    assign take = pkt.valid & pkt.ready;
    assign goal_mv = (state_r == ST_RAMP) ? VT_LT10_MV : target_mv;
    assign ce_byte = ce_value(goal_mv, rectifier_voltage_i);
    assign rp_byte = received_power_sense_i[15:8];

    // packet offer for the state; nothing is ever awaited back
    always_comb begin
        pkt.valid = 1'b0;
        pkt.hdr = HDR_CE;
        pkt.len = 3'h1;
        pkt.body = {48'h0, ce_byte};
        unique case (state_r)
            ST_SIG: begin
                pkt.valid = 1'b1;
                pkt.hdr = HDR_SIG;
                pkt.len = LEN_SIG;
                pkt.body = {48'h0, rectifier_voltage_i[15:8]};
            end
            ST_CFG: begin
                pkt.valid = 1'b1;
                pkt.hdr = HDR_CFG;
                pkt.len = LEN_CFG;
                pkt.body = {16'h0, CFG_BYTES};
            end
            ST_ID: begin
                pkt.valid = 1'b1;
                pkt.hdr = HDR_ID;
                pkt.len = LEN_ID;
                pkt.body = ID_BYTES;
            end
            ST_RAMP: begin
                pkt.valid = 1'b1;
            end
            ST_ACTIVE: begin
                pkt.valid = 1'b1;
                if (ce_cnt_r == RP_EVERY) begin
                    pkt.hdr = HDR_RP;
                    pkt.body = {48'h0, rp_byte};
                end
            end
            ST_EPT: begin
                pkt.valid = 1'b1;
                pkt.hdr = HDR_EPT;
                pkt.body = {48'h0, EPT_REASON};
            end
            ST_IDLE, ST_STOP: begin
                pkt.valid = 1'b0;
            end
        endcase
    end

    // state transitions
    always_comb begin
        state_nxt = state_r;
        contract_nxt = contract_r;
        out_en_nxt = out_en_r;
        ce_cnt_nxt = ce_cnt_r;
        last_ce_nxt = last_ce_r;
        last_rp_nxt = last_rp_r;
        unique case (state_r)
            ST_IDLE: begin
                if (ping_s) begin
                    state_nxt = end_cond ? ST_EPT : ST_SIG;
                end
            end
            ST_SIG: begin
                if (take) begin
                    state_nxt = ST_CFG;
                end
            end
            ST_CFG: begin
                if (take) begin
                    state_nxt = ST_ID;
                end
            end
            ST_ID: begin
                if (take) begin
                    state_nxt = ST_RAMP;
                    contract_nxt = 1'b1;
                end
            end
            ST_RAMP: begin
                if (end_cond) begin
                    state_nxt = ST_EPT;
                end else if (rectifier_voltage_i > VRAMP_MV) begin
                    state_nxt = ST_ACTIVE;
                    out_en_nxt = 1'b1;
                end else if (take) begin
                    last_ce_nxt = ce_byte;
                end
            end
            ST_ACTIVE: begin
                if (end_cond) begin
                    state_nxt = ST_EPT;
                    out_en_nxt = 1'b0;
                end else if (take) begin
                    if (ce_cnt_r == RP_EVERY) begin
                        ce_cnt_nxt = '0;
                        last_rp_nxt = rp_byte;
                    end else begin
                        ce_cnt_nxt = ce_cnt_r + 1'b1;
                        last_ce_nxt = ce_byte;
                    end
                end
            end
            ST_EPT: begin
                out_en_nxt = 1'b0;
                if (take) begin
                    state_nxt = ST_STOP;
                end
            end
            ST_STOP: begin
                out_en_nxt = 1'b0;
                contract_nxt = 1'b0;
                if (!ping_s) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
        if (!ping_s && state_r != ST_IDLE) begin
            // field gone: drop state, contract, output enable and control error count
            state_nxt = ST_IDLE;
            contract_nxt = 1'b0;
            out_en_nxt = 1'b0;
            ce_cnt_nxt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            contract_r <= 1'b0;
            out_en_r <= 1'b0;
            ce_cnt_r <= '0;
            last_ce_r <= '0;
            last_rp_r <= '0;
        end else begin
            state_r <= state_nxt;
            contract_r <= contract_nxt;
            out_en_r <= out_en_nxt;
            ce_cnt_r <= ce_cnt_nxt;
            last_ce_r <= last_ce_nxt;
            last_rp_r <= last_rp_nxt;
        end
    end

    assign output_enable_o = out_en_r;

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic [15:0] max_output_current_nxt;
    logic wr_go;

    assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_r; // write lands on the edge the master sees ack

    // write decode, read mux, one-cycle ack
    always_comb begin
        ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
        ctrl_nxt = ctrl_r;
        max_output_current_nxt = max_output_current_r;
        dat_nxt = dat_r;
        if (wr_go && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
            ctrl_nxt = wb_dat_i[1:0];
        end
        if (wr_go && wb_adr_i == REG_MAX_OUTPUT_CURRENT) begin
            if (wb_sel_i[0]) begin
                max_output_current_nxt[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                max_output_current_nxt[15:8] = wb_dat_i[15:8];
            end
        end
        if (ack_nxt && !wb_we_i) begin
            unique case (wb_adr_i)
                REG_CTRL: dat_nxt = {30'h0, ctrl_r};
                REG_MAX_OUTPUT_CURRENT: dat_nxt = {16'h0, max_output_current_r};
                REG_STATUS: dat_nxt = {24'h0, last_ce_r[1:0], end_cond, out_en_r, contract_r,
                                       state_r};
                REG_TARGET: dat_nxt = {goal_mv, target_mv};
                REG_REPORT: dat_nxt = {16'h0, last_rp_r, last_ce_r};
                default: dat_nxt = 32'h0; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= '0;
            ctrl_r <= CTRL_RST;
            max_output_current_r <= MAX_OUTPUT_CURRENT_RESET;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            ctrl_r <= ctrl_nxt;
            max_output_current_r <= max_output_current_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
endmodule : wrx_top

// >>> tb/wrx_tx_model.sv
// wrx_tx_model: pad stand-in that powers the receiver and counts line edges
`timescale 1ns/1ps
module wrx_tx_model (
    input wire logic clk_i,
    input wire logic ping_on_i,
    input wire logic line_i,
    output logic ping_power_o,
    output int edge_count_o = 0
);
    logic line_r = 1'b0; // line one cycle back
    // field kept on while asked, listens only
    always @(posedge clk_i) begin
        ping_power_o <= ping_on_i;
        line_r <= line_i;
        edge_count_o <= edge_count_o + int'(line_i != line_r);
    end
endmodule : wrx_tx_model

// >>> tb/wrx_top_properties.sv
// wrx_top_chk: port assertions for the receiver control top
`timescale 1ns/1ps
module wrx_top_chk
    import wrx_pkg::*;
#(parameter int HALF_BIT_CYCLES = HALF_BIT_CYC) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic ping_power_i,
    input wire logic mode_select_a_i,
    input wire logic temperature_control_i,
    input wire logic [15:0] rectifier_voltage_i,
    input wire logic load_modulation_switch_o,
    input wire logic output_enable_o
);
    int hold_r; // cycles the line kept its level
    logic sw_r; // line one cycle back
    // run length of the line level
    always_ff @(posedge clk_i) begin
        sw_r <= load_modulation_switch_o;
        hold_r <= (rst_i || sw_r != load_modulation_switch_o) ? 1 : hold_r + 1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    chk_bit_hold: assert property ($fell(load_modulation_switch_o) |-> hold_r >= HALF_BIT_CYCLES)
        else $error("half bit short");
    chk_oe_ramp: assert property ($rose(output_enable_o) |-> $past(rectifier_voltage_i) > VRAMP_MV)
        else $error("enable below ramp");
    chk_oe_ping: assert property (!ping_power_i [*6] |-> !output_enable_o) else $error("enable no field");
    chk_oe_end: assert property (temperature_control_i [*6] |-> !output_enable_o) else $error("no stop");
    chk_oe_shut: assert property (mode_select_a_i [*6] |-> !output_enable_o) else $error("no shut");
    chk_rst_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !output_enable_o)
        else $error("reset not quiet");
    cov_on: cover property ($rose(output_enable_o));
    cov_off: cover property ($fell(output_enable_o));
    cov_bus: cover property (wb_ack_o);
endmodule : wrx_top_chk
bind wrx_top wrx_top_chk #(.HALF_BIT_CYCLES(HALF_BIT_CYCLES)) u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .ping_power_i, .mode_select_a_i, .temperature_control_i, .rectifier_voltage_i,
    .load_modulation_switch_o, .output_enable_o);

// >>> tb/wrx_top_tb_top.sv
// wrx_top_tb_top: register and pin sequences with expected values
`timescale 1ns/1ps
module wrx_top_tb_top
    import wrx_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, pon = 1'b0, ma = 1'b0, ws = 1'b0, tc = 1'b0, mb = 1'b0;
    logic [7:0] adr = '0;
    logic [31:0] dat = '0, rd, q;
    logic [15:0] rect = '0, iout = '0;
    logic ack, ping, sw, oe;
    int edges, e0, err_count = 0, num_checks = 0;
    wrx_state_e seq [4] = '{ST_SIG, ST_CFG, ST_ID, ST_RAMP};
    logic [15:0] cur [7] = '{16'h19, 16'h32, 16'h4b, 16'h64, 16'h96, 16'hc8, 16'hfa};
    logic [15:0] tgt [7] = '{VT_LT10_MV, VT_LT20_MV, VT_LT20_MV, VT_LT40_MV, VT_LT40_MV, VT_HI_MV, VT_HI_MV};
    logic [3:0] cause [5] = '{4'h5, 4'h8, 4'h4, 4'h2, 4'h0}; // wired with b, mode a, wired, temperature, run off
    always #2 clk_i = ~clk_i;
    wrx_top #(.HALF_BIT_CYCLES(20)) u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .ping_power_i(ping),
        .mode_select_a_i(ma), .mode_select_b_i(mb), .wired_supply_i(ws), .temperature_control_i(tc),
        .rectifier_voltage_i(rect), .output_current_i(iout), .received_power_sense_i(16'h5a00),
        .load_modulation_switch_o(sw), .output_enable_o(oe));
    wrx_tx_model u_tx (.clk_i, .ping_on_i(pon), .line_i(sw), .ping_power_o(ping), .edge_count_o(edges));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one classic cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        {cyc, we, adr, dat} <= {1'b1, w, a, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        r = rd;
        cyc <= 1'b0;
    endtask : wb
    // poll status until it reaches (or leaves) a state
    task automatic poll(input logic [2:0] s, input logic lv, output logic [31:0] r);
        do wb(1'b0, REG_STATUS, '0, r); while ((r[2:0] === s) == lv);
    endtask : poll
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (90000) @(posedge clk_i);
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, REG_CTRL, '0, q);
        chk(q[1:0], CTRL_RST);
        wb(1'b1, REG_MAX_OUTPUT_CURRENT, 32'h1f4, q);
        wb(1'b0, REG_MAX_OUTPUT_CURRENT, '0, q);
        chk(q[15:0], 16'h1f4);
        wb(1'b0, 8'h20, '0, q);
        chk(q, 32'h0);
        {rect, iout, pon} <= {16'h1388, 16'h19, 1'b1};
        foreach (seq[i]) begin
            poll(seq[i], 1'b0, q);
            chk(q[2:0], seq[i]);
        end
        chk({oe, q[4:3]}, 3'h1);
        repeat (5000) @(posedge clk_i);
        wb(1'b0, REG_REPORT, '0, q);
        chk({edges != 0, q[7:0]}, 9'h141);
        rect <= 16'h1bbc;
        poll(ST_ACTIVE, 1'b0, q);
        chk(q[4:0], 5'h1f);
        foreach (cur[i]) begin
            iout <= cur[i];
            @(posedge clk_i);
            wb(1'b0, REG_TARGET, '0, q);
            chk(q[15:0], tgt[i]);
        end
        repeat (20000) @(posedge clk_i);
        wb(1'b0, REG_REPORT, '0, q);
        chk({oe, q[15:0]}, 17'h15ac1);
        tc <= 1'b1;
        poll(ST_STOP, 1'b0, q);
        chk({oe, q[2:0]}, {1'b0, ST_STOP});
        e0 = edges; // first edge of the end packet already counted
        for (int k = 0; k < 5; k++) begin
            {ma, ws, tc, mb, pon} <= '0;
            poll(ST_IDLE, 1'b0, q);
            {ma, ws, tc, mb} <= cause[k];
            wb(1'b1, REG_CTRL, {31'h0, k < 4}, q);
            pon <= 1'b1;
            poll(ST_IDLE, 1'b1, q);
            chk(q[2:0], (k == 0) ? ST_SIG : ST_EPT);
        end
        // two end packets of 62 edges each: 44 bit starts, 17 ones, final drop
        repeat (3600) @(posedge clk_i);
        chk(edges - e0, 123);
        wrap_up();
    end
endmodule : wrx_top_tb_top
